// [spi_flash_status_protect_id.sv]
`default_nettype none
module spi_flash_status_protect_id #(
  parameter logic [7:0] MAKER_CODE = 8'h5a, // arbitrary value
  parameter logic [7:0] PART_CODE  = 8'h3c  // arbitrary value
) (
  // system
  input  wire logic i_sys_clk,
  input  wire logic i_rst,
  // serial link pins
  input  wire logic i_sck,
  input  wire logic i_sel_n,
  input  wire logic i_sdi,
  output logic      o_sdo,
  output logic      o_sdo_oe_n,
  // protection pin
  input  wire logic i_wp_n,
  // status view
  output logic      o_protect_level_bit0,
  output logic      o_protect_level_bit1,
  output logic      o_protect_lock_bit,
  output logic      o_armed
);
  typedef enum {ST_OPCODE, ST_ADDR, ST_ID_OUT, ST_DATA, ST_SKIP} phase_e;

  // double-flop synchronisers; first stage read only by the second
  logic [2:0] sync1_q, sync2_q;
  logic       sck_prev_q, sel_prev_q;
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      // idle pin levels: wp high, select high, sck low; a low wp here
      // would look like a locked pin straight after reset
      sync1_q    <= 3'h6;
      sync2_q    <= 3'h6;
      sck_prev_q <= 1'b0;
      sel_prev_q <= 1'b1;
    end else begin
      sync1_q    <= {i_wp_n, i_sel_n, i_sck};
      sync2_q    <= sync1_q;
      sck_prev_q <= sync2_q[0];
      sel_prev_q <= sync2_q[1];
    end
  end
  logic sck_s, sel_n_s, wp_n_s;
  assign sck_s   = sync2_q[0];
  assign sel_n_s = sync2_q[1];
  assign wp_n_s  = sync2_q[2];
  logic sck_rise, sck_fall, sel_rise, active;
  assign sck_rise = sck_s & ~sck_prev_q & ~sel_n_s;
  assign sck_fall = ~sck_s & sck_prev_q & ~sel_n_s;
  assign sel_rise = sel_n_s & ~sel_prev_q;
  assign active   = ~sel_n_s;

  // frame decoder
  phase_e     phase_q;
  logic [5:0] cnt_q;
  logic [7:0] shift_q;
  logic [7:0] opcode_q;
  logic [7:0] data_q;
  logic       id_sel_q;
  logic [7:0] out_q;
  logic [2:0] out_bit_q;
  logic [7:0] shift_d;
  logic       sdi_s;
  // data pin delayed as far as sck, so each bit meets its own rise
  assign shift_d = {shift_q[6:0], sdi_s};

  // data pin synchroniser
  logic sdi1_q, sdi2_q;
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      sdi1_q <= 1'b0;
      sdi2_q <= 1'b0;
    end else begin
      sdi1_q <= i_sdi;
      sdi2_q <= sdi1_q;
    end
  end
  assign sdi_s = sdi2_q;

  function automatic logic is_identify(input logic [7:0] op);
    return (op == spi_flash_status_protect_id_pkg::OP_IDENTIFY_A) ||
           (op == spi_flash_status_protect_id_pkg::OP_IDENTIFY_B);
  endfunction

  always_ff @(posedge i_sys_clk) begin
    if (i_rst || !active) begin
      phase_q  <= ST_OPCODE;
      cnt_q    <= 6'h00;
      shift_q  <= 8'h00;
      opcode_q <= 8'h00;
      data_q   <= 8'h00;
      id_sel_q <= 1'b0;
    end else if (sck_rise) begin
      shift_q <= shift_d;
      cnt_q   <= cnt_q + 6'h01;
      case (phase_q)
        ST_OPCODE: begin
          if (cnt_q + 6'h01 == spi_flash_status_protect_id_pkg::OP_END) begin
            opcode_q <= shift_d;
            cnt_q    <= 6'h00;
            if (is_identify(shift_d)) phase_q <= ST_ADDR;
            else if (shift_d == spi_flash_status_protect_id_pkg::OP_STATUS_WRITE)
              phase_q <= ST_DATA;
            else phase_q <= ST_SKIP;
          end
        end
        ST_ADDR: begin
          if (cnt_q + 6'h01 == 6'(spi_flash_status_protect_id_pkg::ADDR_BITS)) begin
            id_sel_q <= shift_d[0];
            phase_q  <= ST_ID_OUT;
          end
        end
        ST_DATA: begin
          if (cnt_q + 6'h01 == 6'(spi_flash_status_protect_id_pkg::DATA_BITS)) begin
            data_q  <= shift_d; // msb first
            phase_q <= ST_SKIP;
          end
        end
        ST_ID_OUT: cnt_q <= cnt_q;
        ST_SKIP:   cnt_q <= cnt_q;
        default:   phase_q <= ST_SKIP;
      endcase
    end
  end

  // identify output shifter, changes on falling edges
  logic id_start;
  assign id_start = (phase_q == ST_ADDR) && sck_rise &&
                    (cnt_q + 6'h01 == 6'(spi_flash_status_protect_id_pkg::ADDR_BITS));
  always_ff @(posedge i_sys_clk) begin
    if (i_rst || !active) begin
      out_q     <= 8'h00;
      out_bit_q <= 3'h7;
      o_sdo     <= 1'b0;
      o_sdo_oe_n <= 1'b1;
    end else if (id_start) begin
      out_q     <= shift_d[0] ? PART_CODE : MAKER_CODE;
      out_bit_q <= 3'h7;
    end else if (phase_q == ST_ID_OUT && sck_fall) begin
      o_sdo      <= out_q[out_bit_q];
      o_sdo_oe_n <= 1'b0;
      out_bit_q  <= out_bit_q - 3'h1;
      if (out_bit_q == 3'h0)
        out_q <= (out_q == MAKER_CODE) ? PART_CODE : MAKER_CODE; // alternate
    end
  end

  // arm flag and protection bits, both act on select rising
  spi_flash_status_protect_id_pkg::prot_s prot_q, prot_d;
  logic armed_q, frame_arm, frame_wr, permit;
  assign frame_arm = (opcode_q == spi_flash_status_protect_id_pkg::OP_STATUS_WRITE_ARM);
  assign frame_wr  = (opcode_q == spi_flash_status_protect_id_pkg::OP_STATUS_WRITE) &&
                     (phase_q == ST_SKIP);
  // prior lock and pin sampled before the select edge is seen
  assign permit = wp_n_s | ~prot_q.lock;
  always_comb begin
    prot_d      = prot_q;
    prot_d.pl0  = data_q[spi_flash_status_protect_id_pkg::PL0_POS];
    prot_d.pl1  = data_q[spi_flash_status_protect_id_pkg::PL1_POS];
    prot_d.lock = data_q[spi_flash_status_protect_id_pkg::LOCK_POS]; // lock taken from the byte even while pin low, as long as it is not yet set
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      armed_q <= 1'b0;
    end else if (sel_rise) begin
      armed_q <= frame_arm && (phase_q == ST_SKIP); // any other frame disarms
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      prot_q <= spi_flash_status_protect_id_pkg::PROT_RST;
    end else if (sel_rise && frame_wr && armed_q && permit) begin
      prot_q <= prot_d;
    end
  end

  assign o_protect_level_bit0 = prot_q.pl0;
  assign o_protect_level_bit1 = prot_q.pl1;
  assign o_protect_lock_bit   = prot_q.lock;
  assign o_armed              = armed_q;

  // assertions
  a_lock_hold_low: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    (prot_q.lock && !wp_n_s) |=> prot_q.lock)
    else $error("lock cleared while pin low");
  a_write_needs_arm: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    (prot_q != $past(prot_q)) |-> $past(armed_q))
    else $error("status changed without arm");
  a_write_on_edge: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    (prot_q != $past(prot_q)) |-> $past(sel_rise))
    else $error("status changed off select edge");
  a_locked_ignore: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    (sel_rise && prot_q.lock && !wp_n_s) |=> $stable(prot_q))
    else $error("write accepted while locked");
  a_write_takes: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    (sel_rise && frame_wr && armed_q && wp_n_s) |=> prot_q.lock == $past(data_q[7]))
    else $error("free write not applied");
  a_arm_clear: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    (sel_rise && !frame_arm) |=> !armed_q)
    else $error("arm survived other frame");
  a_arm_set: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    (sel_rise && frame_arm && phase_q == ST_SKIP) |=> armed_q)
    else $error("arm not taken");
  a_id_first: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    id_start |=> out_q == ($past(shift_d[0]) ? PART_CODE : MAKER_CODE))
    else $error("wrong first id byte");
  a_sdo_idle: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    !active ##1 !active |-> o_sdo_oe_n)
    else $error("output driven while deselected");

  // level bits follow the byte on every permitted write
  a_levels_take: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    (sel_rise && frame_wr && armed_q && permit) |=>
      (prot_q.pl0 == $past(data_q[spi_flash_status_protect_id_pkg::PL0_POS])) &&
      (prot_q.pl1 == $past(data_q[spi_flash_status_protect_id_pkg::PL1_POS])))
    else $error("level bits not applied");

  // pin low and unlocked: the lock may still be set in one write
  a_lock_set_low: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    (sel_rise && frame_wr && armed_q && !wp_n_s && !prot_q.lock) |=>
      (prot_q.lock == $past(data_q[spi_flash_status_protect_id_pkg::LOCK_POS])))
    else $error("lock not set while pin low");

  // without a pending arm nothing in the status may move
  a_unarmed_ignore: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    (sel_rise && !armed_q) |=> $stable(prot_q))
    else $error("status moved without arm");

  // the whole update is the value computed before the select edge
  a_permit_prior: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    (sel_rise && frame_wr && armed_q && permit) |=> (prot_q == $past(prot_d)))
    else $error("update differs from prior value");

  // arm flag only rises at the end of a frame
  a_arm_on_edge: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    $rose(armed_q) |-> $past(sel_rise))
    else $error("arm set off select edge");

  // either identify opcode leads into the address phase
  a_id_route: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    (phase_q == ST_OPCODE && sck_rise &&
     (cnt_q + 6'h01 == spi_flash_status_protect_id_pkg::OP_END) &&
     is_identify(shift_d)) |=> (phase_q == ST_ADDR))
    else $error("identify opcode not decoded");

  // write byte is captured whole, msb first
  a_data_msb: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    (phase_q == ST_DATA && sck_rise &&
     (cnt_q + 6'h01 == 6'(spi_flash_status_protect_id_pkg::DATA_BITS))) |=>
      (data_q == $past(shift_d)))
    else $error("write byte misassembled");

  // the pin is driven only while identify bytes stream out
  a_oe_only_id: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    !o_sdo_oe_n |-> (phase_q == ST_ID_OUT))
    else $error("output driven outside identify");

  // each falling edge launches the current bit of the current code
  a_sdo_bit: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    (phase_q == ST_ID_OUT && sck_fall) |=> (o_sdo == $past(out_q[out_bit_q])))
    else $error("wrong identify bit launched");

  // after the last bit of a byte the other code follows; needs distinct codes
  a_id_alternate: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    (phase_q == ST_ID_OUT && sck_fall && out_bit_q == 3'h0) |=>
      (out_q != $past(out_q)))
    else $error("identify bytes not alternating");

  c_arm:   cover property (@(posedge i_sys_clk) sel_rise && frame_arm);
  c_write: cover property (@(posedge i_sys_clk) sel_rise && frame_wr && armed_q && permit);
  c_lock:  cover property (@(posedge i_sys_clk) prot_q.lock && !wp_n_s);
  c_id:    cover property (@(posedge i_sys_clk) id_start);
  // stream long enough to finish a byte and switch to the other code
  c_id_alt: cover property (@(posedge i_sys_clk)
    phase_q == ST_ID_OUT && sck_fall && out_bit_q == 3'h0);
endmodule
`default_nettype wire

// [spi_flash_status_protect_id_pkg.sv]
`default_nettype none
package spi_flash_status_protect_id_pkg;

  // opcodes
  localparam logic [7:0] OP_STATUS_WRITE_ARM = 8'h50;
  localparam logic [7:0] OP_STATUS_WRITE     = 8'h01;
  localparam logic [7:0] OP_IDENTIFY_A       = 8'h90;
  localparam logic [7:0] OP_IDENTIFY_B       = 8'hab;

  // status field positions
  localparam int unsigned PL0_POS  = 2;
  localparam int unsigned PL1_POS  = 3;
  localparam int unsigned LOCK_POS = 7;

  // reset values of the protection bits
  localparam logic PL0_RST  = 1'b1;
  localparam logic PL1_RST  = 1'b1;
  localparam logic LOCK_RST = 1'b0;

  // frame bit counts
  localparam int unsigned OPCODE_BITS = 8;
  localparam int unsigned ADDR_BITS   = 24;
  localparam int unsigned DATA_BITS   = 8;
  localparam logic [5:0]  OP_END      = 6'h08;
  localparam logic [5:0]  ADDR_END    = 6'h20;
  localparam logic [5:0]  DATA_END    = 6'h10;

  // status protection bits travelling together
  typedef struct packed {
    logic lock;
    logic pl1;
    logic pl0;
  } prot_s;

  localparam prot_s PROT_RST = '{lock: LOCK_RST, pl1: PL1_RST, pl0: PL0_RST};

endpackage
`default_nettype wire

// [spi_host_model.sv]
`default_nettype none
module spi_host_model (
  // system
  input  wire logic i_sys_clk,
  // serial link
  output logic      o_sck,
  output logic      o_sel_n,
  output logic      o_sdi,
  input  wire logic i_sdo
);
  timeunit 1ns;
  timeprecision 1ns;

  initial begin
    o_sck   = 1'b0;
    o_sel_n = 1'b1;
    o_sdi   = 1'b0;
  end

  task automatic hw(input int n);
    repeat (n) @(posedge i_sys_clk);
  endtask

  // whole frame msb first, sck still outside it
  task automatic frame(input logic [47:0] bits, input int n, output logic [15:0] rx);
    rx = 16'h0;
    @(posedge i_sys_clk);
    o_sel_n <= 1'b0;
    hw(4);
    for (int i = 0; i < n; i++) begin
      o_sdi <= bits[47 - i];
      hw(4);
      o_sck <= 1'b1;
      hw(4);
      // sampled late in the high phase, well after the fall that launched it
      rx = {rx[14:0], i_sdo};
      o_sck <= 1'b0;
    end
    hw(4);
    o_sel_n <= 1'b1;
    // released line must not keep showing the last bit
    o_sdi <= ~o_sdi;
    hw(10);
  endtask
endmodule
`default_nettype wire

// [spi_flash_status_protect_id_tb_top.sv]
`default_nettype none
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin fail_count++; \
  $display("mismatch t=%0t got=%h exp=%h", $time, a, b); end end
module spi_flash_status_protect_id_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [7:0] MK = 8'h5a; // arbitrary value
  localparam logic [7:0] PT = 8'h3c; // arbitrary value
  logic        i_sys_clk, i_rst, sck, sel_n, sdi, sdo, sdo_oe_n, wp_n;
  logic        pl0, pl1, lock, armed;
  int          fail_count = 0;
  int          checked = 0;
  logic [31:0] seed = 32'hf7350979;
  logic [31:0] r;
  logic [15:0] rx;
  // reference state
  int          m_lock = 0, m_pl1 = 1, m_pl0 = 1, m_armed = 0;

  spi_flash_status_protect_id #(.MAKER_CODE(MK), .PART_CODE(PT)) dut_u (
    .i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_sck(sck), .i_sel_n(sel_n), .i_sdi(sdi),
    .o_sdo(sdo), .o_sdo_oe_n(sdo_oe_n), .i_wp_n(wp_n), .o_protect_level_bit0(pl0),
    .o_protect_level_bit1(pl1), .o_protect_lock_bit(lock), .o_armed(armed));
  spi_host_model host_u (
    .i_sys_clk(i_sys_clk), .o_sck(sck), .o_sel_n(sel_n), .o_sdi(sdi), .i_sdo(sdo));

  initial begin
    i_sys_clk = 1'b0;
    forever #50 i_sys_clk = ~i_sys_clk;
  end

  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  task automatic arm();
    host_u.frame({spi_flash_status_protect_id_pkg::OP_STATUS_WRITE_ARM, 40'h0}, 8, rx);
    m_armed = 1;
    `CHK(armed, 1'b1)
  endtask

  // pin flips mid-frame; only its value before select rises counts
  task automatic wr(input logic a, input logic [7:0] d, input logic w);
    if (a) arm();
    wp_n <= ~w;
    fork
      host_u.frame({spi_flash_status_protect_id_pkg::OP_STATUS_WRITE, d, 32'h0}, 16, rx);
      begin
        repeat (40) @(posedge i_sys_clk);
        wp_n <= w;
      end
    join
    if (m_armed == 1 && !(w == 1'b0 && m_lock == 1)) begin
      m_lock = d[7];
      m_pl1 = d[3];
      m_pl0 = d[2];
    end
    m_armed = 0;
    `CHK({lock, pl1, pl0, armed}, {m_lock[0], m_pl1[0], m_pl0[0], 1'b0})
  endtask

  task automatic ident(input logic [7:0] op, input logic a0);
    r = xs();
    // only address bit zero may be set
    host_u.frame({op, 23'h0, a0, r[15:0]}, 48, rx);
    m_armed = 0;
    `CHK(rx, a0 ? {PT, MK} : {MK, PT})
    `CHK({sdo_oe_n, armed}, 2'h2)
  endtask

  task automatic test_done();
    $display("checked=%0d fail_count=%0d", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  initial begin
    // the scenarios need about 11k clocks; 50k, over four times that, is a hang
    #5_000_000;
    fail_count++;
    test_done();
  end

  initial begin
    i_rst = 1'b1;
    wp_n = 1'b1;
    repeat (8) @(posedge i_sys_clk);
    i_rst <= 1'b0;
    // power-up wait before the first frame
    repeat (100) @(posedge i_sys_clk);
    `CHK({lock, pl1, pl0, armed, sdo_oe_n}, 5'h0d)
    wr(1'b0, 8'h00, 1'b1);
    arm();
    ident(spi_flash_status_protect_id_pkg::OP_IDENTIFY_A, 1'b0);
    wr(1'b0, 8'h00, 1'b1);
    for (int i = 0; i < 4; i++)
      ident(i[1] ? spi_flash_status_protect_id_pkg::OP_IDENTIFY_B
                 : spi_flash_status_protect_id_pkg::OP_IDENTIFY_A, i[0]);
    wr(1'b1, 8'h80, 1'b0);
    wr(1'b1, 8'h0c, 1'b0);
    wr(1'b1, 8'h0c, 1'b1);
    for (int i = 0; i < 40; i++) begin
      r = xs();
      wr(r[0], r[15:8], r[1]);
    end
    test_done();
  end
endmodule
`default_nettype wire
